// ### rtl/usart_pkg.sv
// Shared constants and carrier types for the serial clock and frame unit.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package usart_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets)
    localparam logic [4:0] OFS_CTRL      = 5'h00;
    localparam logic [4:0] OFS_BAUD_LOW  = 5'h04;
    localparam logic [4:0] OFS_BAUD_HIGH = 5'h08;
    localparam logic [4:0] OFS_DATA      = 5'h0C;
    localparam logic [4:0] OFS_STATUS    = 5'h10;

    // Control register field positions
    localparam int CTL_POWER_OFF = 0;
    localparam int CTL_TX_EN     = 1;
    localparam int CTL_RX_EN     = 2;
    localparam int CTL_SYNC      = 3;
    localparam int CTL_DOUBLE    = 4;
    localparam int CTL_PIN_DIR   = 5;
    localparam int CTL_POLARITY  = 6;
    localparam int CTL_STOP2     = 7;
    localparam int CTL_CSZ_LO    = 8;
    localparam int CTL_PAR_LO    = 11;
    localparam int CTL_WIDTH     = 13;
    localparam logic [12:0] CTRL_RESET = 13'h0001;

    // Status register field positions
    localparam int ST_TX_EMPTY = 0;
    localparam int ST_TX_DONE  = 1;
    localparam int ST_RX_AVAIL = 2;
    localparam int ST_OVERRUN  = 3;
    localparam int ST_FERR     = 4;
    localparam int ST_PERR     = 5;
    localparam int ST_TX_BUSY  = 6;

    // Data register read layout: data [8:0], frame error 9, parity error 10
    localparam int DAT_FERR = 9;
    localparam int DAT_PERR = 10;

    ////////////////////////////////////////////////////////////////////////
    // Divider and sampling figures
    localparam int BAUD_WIDTH    = 12;
    localparam int DIV_NORMAL    = 16;
    localparam int DIV_DOUBLE    = 8;
    localparam int DIV_MASTER    = 2;
    localparam logic [2:0] CSZ_NINE = 3'h7;
    localparam logic [1:0] PAR_EVEN = 2'h2;
    localparam logic [1:0] PAR_ODD  = 2'h3;
    localparam int RX_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic       stop2;
        logic [1:0] parity_mode;
        logic [2:0] char_size;
    } frame_cfg_t;

    typedef struct packed {
        logic       perr;
        logic       ferr;
        logic [8:0] data;
    } rx_entry_t;

    typedef enum {
        LINE_IDLE,
        LINE_START,
        LINE_DATA,
        LINE_PARITY,
        LINE_STOP
    } line_state_t;

endpackage

// ### rtl/usart_core.sv
// Serial unit: baud generator, clock modes, frame transmit and receive.
// Assumes a synchronous Avalon-MM master and pins synchronous to core_clk,
// except the transfer clock input, which is resynchronised here.
//
// Functional notes
// - Four clock modes: async normal, async double, sync master, sync slave.
// - In sync mode the clock pin direction picks master or slave.
// - Transfer clock pin is unused in asynchronous modes.
// - Baud down-counter reloads at zero and on divisor low byte write.
// - One baud tick per counter zero, rate clock over divisor plus one.
// - Transmitter divides the tick by 16, 8 or 2 by mode.
// - Receiver runs 2, 8 or 16 tick states per bit by mode.
// - Baud divisor is 12 bits from a high and a low byte.
// - Double speed acts only in asynchronous operation.
// - Double speed receiver uses 8 ticks per bit, not 16.
// - External clock passes a synchroniser and edge detector, two cycles.
// - Sync data changes on one clock edge, sampled on the other.
// - All 30 frame formats of size, parity and stop bits accepted.
// - Low start bit, data LSB first, parity, then high stop bits.
// - Frames may follow back to back, else the line idles high.
// - Transmitter and receiver share one frame format setting.
// - Size, parity mode and stop select fields shape the frame.
// - Receiver checks only the first stop bit for frame error.
// - Single transmit buffer ahead of the shift register.
// - Receiver has parity check, shifter, two-level buffer, error flags.
// - Parity is xor of data bits, inverted for odd.
// - Character size value 7 selects nine data bits.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module usart_core
    import usart_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Serial pins
    output logic             serial_tx_pin,
    input  wire logic        serial_rx_pin,
    // Transfer clock pin, three signals
    input  wire logic        xfer_clk_pin_in,
    output logic             xfer_clk_pin_out,
    output logic             xfer_clk_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus decode
    logic [CTL_WIDTH-1:0]  ctrl;
    logic [BAUD_WIDTH-1:0] baud_divisor;
    logic                  bus_ack;
    logic                  tx_done;
    logic                  overrun;

    wire bus_req      = avs_read | avs_write;
    wire wr_go        = avs_write & bus_ack;
    wire rd_go        = avs_read & bus_ack;
    wire lane0        = avs_byteenable[0];
    wire lane1        = avs_byteenable[1];
    wire hit_ctrl     = avs_address == OFS_CTRL;
    wire hit_low      = avs_address == OFS_BAUD_LOW;
    wire hit_high     = avs_address == OFS_BAUD_HIGH;
    wire hit_data     = avs_address == OFS_DATA;
    wire hit_status   = avs_address == OFS_STATUS;
    wire wr_low       = wr_go & hit_low & lane0;
    wire wr_high      = wr_go & hit_high & lane0;
    wire wr_data      = wr_go & hit_data & lane0;
    wire wr_status    = wr_go & hit_status & lane0;
    wire rd_data      = rd_go & hit_data;

    // Every access waits exactly one cycle, giving readdata a register
    assign avs_waitrequest = bus_req & ~bus_ack;

    always_ff @(posedge core_clk) begin
        if (reset)
            bus_ack <= 1'b0;
        else
            bus_ack <= bus_req & ~bus_ack;
    end

    // Control and divisor storage, per byte lane
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl         <= CTRL_RESET;
            baud_divisor <= '0;
        end else begin
            if (wr_go && hit_ctrl && lane0)
                ctrl[7:0] <= avs_writedata[7:0];
            if (wr_go && hit_ctrl && lane1)
                ctrl[CTL_WIDTH-1:8] <= avs_writedata[CTL_WIDTH-1:8];
            if (wr_low)
                baud_divisor[7:0] <= avs_writedata[7:0];
            if (wr_high)
                baud_divisor[BAUD_WIDTH-1:8] <= avs_writedata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    wire powered   = ~ctrl[CTL_POWER_OFF];
    wire tx_on     = powered & ctrl[CTL_TX_EN];
    wire rx_on     = powered & ctrl[CTL_RX_EN];
    wire sync_mode = ctrl[CTL_SYNC];
    wire master    = sync_mode & ctrl[CTL_PIN_DIR];
    wire slave     = sync_mode & ~ctrl[CTL_PIN_DIR];
    wire dbl       = ~sync_mode & ctrl[CTL_DOUBLE];
    wire polarity  = ctrl[CTL_POLARITY];
    // One format shared by both directions; no guard against mid-frame edits
    frame_cfg_t cfg;
    assign cfg.stop2       = ctrl[CTL_STOP2];
    assign cfg.parity_mode = ctrl[CTL_PAR_LO +: 2];
    assign cfg.char_size   = ctrl[CTL_CSZ_LO +: 3];

    // Data bit count: 0..3 give 5..8, 7 gives 9, reserved codes give 8
    wire [3:0] nbits = (cfg.char_size == CSZ_NINE) ? 4'h9 :
                       cfg.char_size[2] ? 4'h8 :
                       4'h5 + {2'b00, cfg.char_size[1:0]};
    wire par_on  = cfg.parity_mode[1];
    wire par_odd = cfg.parity_mode == PAR_ODD;
    wire [8:0] data_mask = 9'h1FF >> (4'h9 - nbits);

    ////////////////////////////////////////////////////////////////////////
    // Baud generator
    logic [BAUD_WIDTH-1:0] baud_cnt;
    wire baud_tick = powered & (baud_cnt == '0);

    // Reload on zero and on low byte write
    always_ff @(posedge core_clk) begin
        if (reset)
            baud_cnt <= '0;
        else if (wr_low)
            baud_cnt <= {baud_divisor[BAUD_WIDTH-1:8],
                         avs_writedata[7:0]};
        else if (baud_cnt == '0)
            baud_cnt <= baud_divisor;
        else
            baud_cnt <= baud_cnt - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer clock: master output and slave synchroniser
    logic xck_int;
    logic xck_meta;
    logic xck_sync;
    logic xck_prev;

    // Master toggles per tick, so a full period is two ticks
    always_ff @(posedge core_clk) begin
        if (reset)
            xck_int <= 1'b0;
        else if (!master)
            xck_int <= polarity;
        else if (baud_tick)
            xck_int <= ~xck_int;
    end

    // Two stages then edge compare; the edge is two cycles late
    always_ff @(posedge core_clk) begin
        if (reset) begin
            xck_meta <= 1'b0;
            xck_sync <= 1'b0;
            xck_prev <= 1'b0;
        end else begin
            xck_meta <= xfer_clk_pin_in;
            xck_sync <= xck_meta;
            xck_prev <= xck_sync;
        end
    end

    wire ext_rise = slave & xck_sync & ~xck_prev;
    wire ext_fall = slave & ~xck_sync & xck_prev;
    // Pin driven only in master mode, tri-stated otherwise
    assign xfer_clk_pin_out  = xck_int;
    assign xfer_clk_pin_oe_n = ~(master & powered);

    // Change and sample edges, swapped by polarity
    wire m_rise = baud_tick & (xck_int == 1'b0);
    wire m_fall = baud_tick & (xck_int == 1'b1);
    wire any_rise = master ? m_rise : ext_rise;
    wire any_fall = master ? m_fall : ext_fall;
    wire sync_change = polarity ? any_fall : any_rise;
    wire sync_sample = polarity ? any_rise : any_fall;

    ////////////////////////////////////////////////////////////////////////
    // Transmit bit pacing
    logic [3:0] tx_pre;
    wire [3:0] tx_div_last = dbl ? 4'(DIV_DOUBLE - 1) : 4'(DIV_NORMAL - 1);
    wire tx_step = sync_mode ? sync_change
                             : baud_tick & (tx_pre == '0);

    always_ff @(posedge core_clk) begin
        if (reset)
            tx_pre <= '0;
        else if (baud_tick)
            tx_pre <= (tx_pre == '0) ? tx_div_last : tx_pre - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter: one buffer word ahead of the shifter
    line_state_t tx_state;
    logic [8:0]  tx_buf;
    logic        tx_buf_full;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_bits;
    logic        tx_par;
    logic        tx_stop_left;

    wire tx_load = tx_step & tx_buf_full & tx_on &
                   (tx_state == LINE_IDLE ||
                    (tx_state == LINE_STOP && !tx_stop_left));
    wire tx_frame_end = tx_step & tx_state == LINE_STOP & ~tx_stop_left;

    // Buffer fill from bus, drain into shifter
    always_ff @(posedge core_clk) begin
        if (reset) begin
            tx_buf      <= '0;
            tx_buf_full <= 1'b0;
        end else if (wr_data && !tx_buf_full) begin
            tx_buf      <= avs_writedata[8:0];
            tx_buf_full <= 1'b1;
        end else if (tx_load) begin
            tx_buf_full <= 1'b0;
        end
    end

    // Frame sequencer
    always_ff @(posedge core_clk) begin
        if (reset || !tx_on) begin
            tx_state      <= LINE_IDLE;
            serial_tx_pin <= 1'b1;
            tx_shift      <= '0;
            tx_bits       <= '0;
            tx_par        <= 1'b0;
            tx_stop_left  <= 1'b0;
        end else if (tx_load) begin
            tx_state      <= LINE_START;
            serial_tx_pin <= 1'b0;
            tx_shift      <= tx_buf & data_mask;
            tx_bits       <= nbits;
            tx_par        <= ^(tx_buf & data_mask) ^ par_odd;
        end else if (tx_step) begin
            unique case (tx_state)
                LINE_IDLE: begin
                    serial_tx_pin <= 1'b1;
                end
                LINE_START, LINE_DATA: begin
                    if (tx_bits != '0) begin
                        tx_state      <= LINE_DATA;
                        serial_tx_pin <= tx_shift[0];
                        tx_shift      <= tx_shift >> 1;
                        tx_bits       <= tx_bits - 1'b1;
                    end else if (par_on) begin
                        tx_state      <= LINE_PARITY;
                        serial_tx_pin <= tx_par;
                    end else begin
                        tx_state      <= LINE_STOP;
                        serial_tx_pin <= 1'b1;
                        tx_stop_left  <= cfg.stop2;
                    end
                end
                LINE_PARITY: begin
                    tx_state      <= LINE_STOP;
                    serial_tx_pin <= 1'b1;
                    tx_stop_left  <= cfg.stop2;
                end
                LINE_STOP: begin
                    serial_tx_pin <= 1'b1;
                    if (tx_stop_left)
                        tx_stop_left <= 1'b0;
                    else
                        tx_state <= LINE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive sample pacing
    logic [3:0] rx_phase;
    wire [3:0] rx_last = tx_div_last;
    wire [3:0] rx_mid  = rx_last >> 1;
    line_state_t rx_state;
    wire rx_hunt = ~sync_mode & rx_state == LINE_IDLE &
                   baud_tick & ~serial_rx_pin;
    // Async samples mid-bit; sync samples on the clock's sample edge
    wire rx_samp = sync_mode ? sync_sample
                             : baud_tick & (rx_phase == rx_mid);

    always_ff @(posedge core_clk) begin
        if (reset || rx_hunt)
            rx_phase <= '0;
        else if (baud_tick)
            rx_phase <= (rx_phase == rx_last) ? '0 : rx_phase + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver shifter and checks
    logic [8:0] rx_shift;
    logic [3:0] rx_bits;
    logic       rx_perr;
    logic       rx_push;
    rx_entry_t  rx_new;

    wire [8:0] rx_aligned = rx_shift >> (4'h9 - nbits);
    wire rx_par_exp = ^rx_aligned ^ par_odd;

    always_ff @(posedge core_clk) begin
        if (reset || !rx_on) begin
            rx_state <= LINE_IDLE;
            rx_shift <= '0;
            rx_bits  <= '0;
            rx_perr  <= 1'b0;
            rx_push  <= 1'b0;
            rx_new   <= '0;
        end else begin
            rx_push <= 1'b0;
            unique case (rx_state)
                LINE_IDLE: begin
                    if (rx_hunt)
                        rx_state <= LINE_START;
                    else if (sync_mode && rx_samp && !serial_rx_pin)
                        rx_state <= LINE_DATA;
                    rx_bits <= nbits;
                    rx_perr <= 1'b0;
                end
                LINE_START: begin
                    // False start rejected if line rose by mid-bit
                    if (rx_samp)
                        rx_state <= serial_rx_pin ? LINE_IDLE : LINE_DATA;
                end
                LINE_DATA: begin
                    if (rx_samp) begin
                        rx_shift <= {serial_rx_pin, rx_shift[8:1]};
                        rx_bits  <= rx_bits - 1'b1;
                        if (rx_bits == 4'h1)
                            rx_state <= par_on ? LINE_PARITY : LINE_STOP;
                    end
                end
                LINE_PARITY: begin
                    if (rx_samp) begin
                        rx_perr  <= serial_rx_pin != rx_par_exp;
                        rx_state <= LINE_STOP;
                    end
                end
                LINE_STOP: begin
                    // Second stop bit never looked at
                    if (rx_samp) begin
                        rx_new.data <= rx_aligned;
                        rx_new.ferr <= ~serial_rx_pin;
                        rx_new.perr <= rx_perr;
                        rx_push     <= 1'b1;
                        rx_state    <= LINE_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-level receive buffer
    rx_entry_t rx_mem [RX_DEPTH];
    logic [1:0] rx_count;
    wire rx_any  = rx_count != '0;
    wire rx_pop  = rd_data & rx_any;
    wire rx_full = rx_count == 2'(RX_DEPTH);
    wire rx_store = rx_push & (~rx_full | rx_pop);
    wire [1:0] rx_slot = rx_pop ? rx_count - 1'b1 : rx_count;

    // Shift-out buffer: head is always entry 0
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_count  <= '0;
            rx_mem[0] <= '0;
            rx_mem[1] <= '0;
        end else begin
            if (rx_pop)
                rx_mem[0] <= rx_mem[1];
            if (rx_store)
                rx_mem[rx_slot[0]] <= rx_new;
            rx_count <= rx_count + 2'(rx_store) - 2'(rx_pop);
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (reset) begin
            overrun <= 1'b0;
            tx_done <= 1'b0;
        end else begin
            if (rx_push && !rx_store)
                overrun <= 1'b1;
            else if (rx_pop)
                overrun <= 1'b0;
            if (tx_frame_end && !tx_load)
                tx_done <= 1'b1;
            else if (wr_status && avs_writedata[ST_TX_DONE])
                tx_done <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data path
    wire [31:0] status_word = {25'h0, tx_state != LINE_IDLE,
                               rx_mem[0].perr & rx_any,
                               rx_mem[0].ferr & rx_any,
                               overrun, rx_any,
                               tx_done, ~tx_buf_full};
    wire [31:0] data_word = {21'h0, rx_mem[0].perr, rx_mem[0].ferr,
                             rx_mem[0].data};
    wire [31:0] read_mux =
        hit_ctrl   ? {19'h0, ctrl} :
        hit_low    ? {24'h0, baud_divisor[7:0]} :
        hit_high   ? {28'h0, baud_divisor[BAUD_WIDTH-1:8]} :
        hit_data   ? data_word :
        hit_status ? status_word : 32'h0000_0000;

    always_ff @(posedge core_clk) begin
        if (reset)
            avs_readdata <= '0;
        else if (avs_read && !bus_ack)
            avs_readdata <= read_mux;
    end

endmodule

// ### bench/usart_core_asserts.sv
// Checker for the serial unit: bus handshake, read widths, pin states.
// Assumes it is bound to usart_core and sees only its ports.
`timescale 1ns/1ps
module usart_core_asserts
    import usart_pkg::*;
(
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        reset,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Pins
    input wire logic        serial_tx_pin,
    input wire logic        xfer_clk_pin_oe_n
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    ////////////////////////////////////////
    // Access steps: a waiting request, then a finished read
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence

    ////////////////////////////////////////
    // Exactly one wait cycle, none while idle
    AST_WAIT_FIRST: assert property
        ((avs_read || avs_write) && !$past(avs_read || avs_write)
         |-> avs_waitrequest) else $error("no wait on first cycle");
    AST_WAIT_ONE: assert property (req_wait |=> !avs_waitrequest)
        else $error("wait longer than one cycle");
    AST_IDLE_NO_WAIT: assert property
        (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("wait while idle");
    // Read widths follow the field layout
    AST_UNMAPPED: assert property (rd_done ##0 (avs_address > OFS_STATUS)
        |-> avs_readdata == 32'h0000_0000) else $error("unmapped not 0");
    AST_BAUD_HI_WIDTH: assert property
        (rd_done ##0 (avs_address == OFS_BAUD_HIGH)
        |-> avs_readdata[31:4] == 28'h000_0000) else $error("divisor wide");
    AST_CTRL_WIDTH: assert property
        (rd_done ##0 (avs_address == OFS_CTRL)
        |-> avs_readdata[31:13] == 19'h0_0000) else $error("ctrl wide");
    AST_DATA_WIDTH: assert property
        (rd_done ##0 (avs_address == OFS_DATA)
        |-> avs_readdata[31:11] == 21'h00_0000) else $error("data wide");
    // Pins after reset and start bit length
    AST_TX_IDLE: assert property ($fell(reset) |-> serial_tx_pin)
        else $error("tx not idle high");
    AST_OE_RESET: assert property ($fell(reset) |-> xfer_clk_pin_oe_n)
        else $error("clock pin driven after reset");
    AST_START_LEN: assert property
        ($fell(serial_tx_pin) |=> !serial_tx_pin)
        else $error("start bit too short");
endmodule

bind usart_core usart_core_asserts chk (.*);

// ### bench/usart_peer.sv
// Remote serial partner: sends frames to rx, samples frames from tx.
// Assumes tasks are entered just after a core_clk rising edge.
`timescale 1ns/1ps
module usart_peer (
    // Clock
    input wire logic core_clk,
    // Serial lines
    input wire logic line_in,
    output logic     line_out
);
    // Line idles high between frames
    initial line_out = 1'b1;

    // Frame bits go out first bit first, as built by the bench
    task automatic send(input logic [12:0] f, input int len, input int bt);
        for (int i = 0; i < len; i++) begin
            line_out <= f[i];
            repeat (bt) @(posedge core_clk);
        end
        line_out <= 1'b1;
    endtask

    // Waits for a start edge, then samples each bit at its middle
    task automatic recv(input int len, input int bt, output logic [12:0] f);
        f = 13'h1FFF;
        while (line_in !== 1'b0) @(posedge core_clk);
        repeat (bt / 2) @(posedge core_clk);
        for (int i = 0; i < len; i++) begin
            f[i] = line_in;
            repeat (bt) @(posedge core_clk);
        end
    endtask
endmodule

// ### bench/usart_clock_and_frame_format_tb.sv
// Bench: bus tasks, frame format table both ways, master clock rate.
// Assumes usart_peer on the serial lines; checker bound to usart_core.
`timescale 1ns/1ps
module usart_clock_and_frame_format_tb
    import usart_pkg::*;
;
    localparam int DIVISOR = 1;
    typedef struct packed {
        logic       dbl;
        logic [2:0] csz;
        logic [1:0] pm;
        logic       s2;
        logic       bp;
        logic       bs;
        logic [8:0] d;
    } case_t;
    logic        core_clk = 1'b0;
    logic        reset = 1'b1;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata, q;
    logic        avs_waitrequest, serial_tx_pin, serial_rx_pin, xck, oe_n;
    logic [12:0] ef, gf;
    logic [8:0]  dm;
    int          bad_count = 0, checked = 0, nb, bt, len, a, n;
    case_t       c;
    case_t       cs [6];

    ////////////////////////////////////////
    // Clock, design and partner
    always #25 core_clk = ~core_clk;
    usart_core DUT (.core_clk, .reset, .avs_address, .avs_read, .avs_write,
        .avs_byteenable(4'hF), .avs_writedata, .avs_readdata,
        .avs_waitrequest, .serial_tx_pin, .serial_rx_pin,
        .xfer_clk_pin_in(1'b0), .xfer_clk_pin_out(xck),
        .xfer_clk_pin_oe_n(oe_n));
    usart_peer peer (.core_clk, .line_in(serial_tx_pin),
        .line_out(serial_rx_pin));

    ////////////////////////////////////////
    // Compare and finish
    task automatic chk(input logic [31:0] g, e, input string s);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [4:0] ad,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge core_clk);
        avs_address <= ad;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] ad, input logic [31:0] d);
        bus(1'b1, ad, d, q);
    endtask
    task automatic rdc(input logic [4:0] ad, input logic [31:0] e,
                       input string s);
        bus(1'b0, ad, 32'h0000_0000, q);
        chk(q, e, s);
    endtask
    // Poll one status bit; the watchdog bounds it
    task automatic waitst(input int b);
        do bus(1'b0, OFS_STATUS, 32'h0000_0000, q);
        while (q[b] !== 1'b1);
    endtask
    // Falling edges of core_clk until the master clock shows level v
    task automatic lvl(input logic v, output int k);
        k = 0;
        while (xck !== v) begin
            @(negedge core_clk);
            k++;
        end
    endtask

    // Expected line bits: start, data from bit 0, parity, stop bits
    function automatic logic [12:0] mkf(input logic [8:0] d, input int w,
        input logic [1:0] pm, input logic s2, bp, bs, output int ln);
        logic [12:0] f;
        logic        p;
        f = 13'h1FFF;
        f[0] = 1'b0;
        p = (pm == PAR_ODD);
        for (int i = 0; i < w; i++) begin
            f[i + 1] = d[i];
            p ^= d[i];
        end
        ln = w + 1;
        if (pm[1]) f[ln++] = p ^ bp;
        f[ln] = ~bs;
        ln += s2 ? 2 : 1;
        return f;
    endfunction

    ////////////////////////////////////////
    // Watchdog
    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        report_and_stop;
    end

    // Main sequence
    initial begin
        cs = '{'{0, 3, PAR_EVEN, 1, 0, 0, 9'h0A5},
               '{1, 0, PAR_ODD, 0, 0, 0, 9'h013},
               '{0, 7, 2'h0, 0, 0, 0, 9'h1C3},
               '{1, 1, 2'h1, 1, 0, 0, 9'h02A},
               '{0, 2, PAR_ODD, 0, 1, 0, 9'h055},
               '{1, 3, 2'h0, 0, 0, 1, 9'h0F0}};
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        rdc(OFS_CTRL, {19'h0, CTRL_RESET}, "ctrl reset");
        rdc(OFS_STATUS, 32'h0000_0001, "status reset");
        chk(32'(oe_n), 32'h0000_0001, "pin idle");
        wr(5'h14, 32'hFFFF_FFFF);
        rdc(5'h14, 32'h0000_0000, "unmapped");
        wr(OFS_BAUD_HIGH, 32'hFFFF_FFFF);
        rdc(OFS_BAUD_HIGH, 32'h0000_000F, "divisor high");
        wr(OFS_BAUD_HIGH, 32'h0000_0000);
        wr(OFS_BAUD_LOW, DIVISOR);
        $display("test registers done");
        foreach (cs[k]) begin
            c = cs[k];
            nb = (c.csz == CSZ_NINE) ? 9 : c.csz + 5;
            bt = (c.dbl ? DIV_DOUBLE : DIV_NORMAL) * (DIVISOR + 1);
            wr(OFS_CTRL, {19'h0, c.pm, c.csz, c.s2, 2'b00, c.dbl, 4'h6});
            ef = mkf(c.d, nb, c.pm, c.s2, 1'b0, 1'b0, len);
            wr(OFS_DATA, {23'h0, c.d});
            peer.recv(len, bt, gf);
            chk({19'h0, gf}, {19'h0, ef}, "tx frame");
            ef = mkf(c.d, nb, c.pm, c.s2, c.bp, c.bs, len);
            peer.send(ef, len, bt);
            waitst(ST_RX_AVAIL);
            dm = c.d & ((9'h001 << nb) - 9'h001);
            rdc(OFS_DATA, {21'h0, c.bp, c.bs, dm}, "rx entry");
            $display("test format %0d done", k);
        end
        wr(OFS_DATA, 32'h0000_0011);
        while (serial_tx_pin) @(posedge core_clk);
        wr(OFS_DATA, 32'h0000_0022);
        repeat (len * bt + bt / 2 - 4) @(posedge core_clk);
        chk(32'(serial_tx_pin), 32'h0000_0000, "no gap");
        repeat (len * bt) @(posedge core_clk);
        $display("test back to back done");
        wr(OFS_CTRL, 32'h0000_032A);
        @(negedge core_clk);
        chk(32'(oe_n), 32'h0000_0000, "master drives");
        lvl(1'b0, n);
        lvl(1'b1, n);
        lvl(1'b0, a);
        lvl(1'b1, n);
        chk(32'(a + n), 32'(DIV_MASTER * (DIVISOR + 1)), "period");
        wr(OFS_CTRL, 32'h0000_032B);
        @(negedge core_clk);
        chk(32'(oe_n), 32'h0000_0001, "power off");
        $display("test master clock done");
        report_and_stop;
    end
endmodule
